/* File: src/mrwpa_pkg.sv */
// shared constants for the reach, wavelength and page advertising bank
package mrwpa_pkg;

  // ----------------------------------------------------------------
  // byte offsets in the management page
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SINGLEMODE_REACH = 8'h84;
  localparam logic [7:0] OFF_WIDEBAND_MM_REACH = 8'h85;
  localparam logic [7:0] OFF_HIGH_BW_MM_REACH = 8'h86;
  localparam logic [7:0] OFF_EXT_BW_MM_REACH = 8'h87;
  localparam logic [7:0] OFF_LEGACY_MM_REACH = 8'h88;
  localparam logic [7:0] OFF_REACH_RESERVED = 8'h89;
  localparam logic [7:0] OFF_NOMINAL_LAMBDA_HI = 8'h8a;
  localparam logic [7:0] OFF_NOMINAL_LAMBDA_LO = 8'h8b;
  localparam logic [7:0] OFF_LAMBDA_TOL_HI = 8'h8c;
  localparam logic [7:0] OFF_LAMBDA_TOL_LO = 8'h8d;
  localparam logic [7:0] OFF_OPTIONAL_PAGE_SUPPORT = 8'h8e;

  // first byte of the block and how many bytes it spans
  localparam logic [7:0] ADV_BASE = OFF_SINGLEMODE_REACH;
  localparam int ADV_BYTES = 11;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int SCALE_MSB = 7;
  localparam int SCALE_LSB = 6;
  localparam int BASE_KM_MSB = 5;
  localparam int PG_NETPATH_BIT = 7;
  localparam int PG_VENDOR_DIAG_BIT = 6;
  localparam int PG_DIAG_BIT = 5;
  localparam int PG_RESERVED_BIT = 4;
  localparam int PG_FORMFACTOR_BIT = 3;
  localparam int PG_USER_BIT = 2;

  // scale factor codes of the single-mode reach byte
  localparam logic [1:0] SCALE_TENTH = 2'h0;
  localparam logic [1:0] SCALE_ONE = 2'h1;
  localparam logic [1:0] SCALE_TEN = 2'h2;
  localparam logic [1:0] SCALE_RSVD = 2'h3;

  // lane bank codes
  localparam logic [1:0] BANKS_8_LANES = 2'h0;
  localparam logic [1:0] BANKS_16_LANES = 2'h1;
  localparam logic [1:0] BANKS_32_LANES = 2'h2;
  localparam logic [1:0] BANKS_RSVD = 2'h3;

  // multimode class index in the support vector
  localparam int MM_WIDEBAND = 0;
  localparam int MM_HIGH_BW = 1;
  localparam int MM_EXT_BW = 2;
  localparam int MM_LEGACY = 3;

  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] RESERVED_VALUE = 8'h00;

  // image state
  typedef enum logic [1:0] {
    ST_EMPTY = 2'b01,
    ST_VALID = 2'b10
  } mrwpa_state_t;

endpackage

/* File: src/mrwpa_byte_sum.sv */
// registered byte adder giving this block's share of the page checksum
`timescale 1ns/100ps
module mrwpa_byte_sum #(
  parameter int NBYTES = 11
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [NBYTES*8-1:0] bytes_in,
  output logic [7:0] sum_q
);

  logic [7:0] sum_d;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NBYTES < 1)
  begin : g_bad
    $error("mrwpa_byte_sum needs at least one byte");
  end

  // ----------------------------------------------------------------
  // modulo-256 sum
  // ----------------------------------------------------------------
  // low eight bits only, so carries are simply dropped
  always_comb
  begin
    sum_d = 8'h00;
    for (int i = 0; i < NBYTES; i++)
    begin
      sum_d = sum_d + bytes_in[i*8 +: 8];
    end
  end

  // register the sum to keep the adder chain off the read path
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sum_q <= 8'h00;
    end
    else
    begin
      sum_q <= sum_d;
    end
  end

endmodule

/* File: src/mrwpa_adv_bank.sv */
// reach, wavelength and optional page advertising bytes of the module page
`timescale 1ns/100ps

module mrwpa_adv_bank
  import mrwpa_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cfg_update,
  input wire logic is_aoc,
  input wire logic smf_supported,
  input wire logic [3:0] mm_supported,
  input wire logic [1:0] singlemode_reach_scale,
  input wire logic [5:0] singlemode_reach_base_km,
  input wire logic [7:0] wideband_mm_reach_2m,
  input wire logic [7:0] high_bw_mm_reach_2m,
  input wire logic [7:0] ext_bw_mm_reach_2m,
  input wire logic [7:0] legacy_mm_reach_1m,
  input wire logic single_lambda,
  input wire logic lambda_programmable,
  input wire logic use_actual_lambda,
  input wire logic multi_lambda_report,
  input wire logic [15:0] std_nominal_tx_lambda,
  input wire logic [15:0] std_tx_lambda_tolerance,
  input wire logic [15:0] act_nominal_tx_lambda,
  input wire logic [15:0] act_tx_lambda_tolerance,
  input wire logic netpath_pages_present,
  input wire logic vendor_diag_pages_present,
  input wire logic diag_pages_present,
  input wire logic formfactor_page_present,
  input wire logic user_page_present,
  input wire logic [1:0] lane_bank_count_code,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] rd_data_q,
  output logic rd_valid_q,
  output logic rd_hit_q,
  output logic image_valid,
  output logic [7:0] csum_part_q
);

  mrwpa_state_t state_q, state_d;
  logic [ADV_BYTES*8-1:0] img_q, img_d;
  logic load;
  logic [7:0] rd_data_d;
  logic rd_valid_d, rd_hit_d;
  logic [7:0] smf_byte, pages_byte;
  logic [15:0] lambda_val, tol_val;
  logic [3:0] mm_ok;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true when the address falls inside this block
  function automatic logic in_block(input logic [7:0] a);
    in_block = (a >= ADV_BASE) && (a < ADV_BASE + 8'(ADV_BYTES));
  endfunction

  // one byte of the image by page address; outside the block reads zero
  function automatic logic [7:0] byte_at(input logic [7:0] a,
                                         input logic [ADV_BYTES*8-1:0] img);
    logic [7:0] idx;
    idx = a - ADV_BASE;
    byte_at = in_block(a) ? img[idx*8 +: 8] : RESERVED_VALUE;
  endfunction

  // ----------------------------------------------------------------
  // image state machine
  // ----------------------------------------------------------------
  // the image is built once after reset and again only on cfg_update
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_EMPTY: state_d = ST_VALID;
      ST_VALID: state_d = ST_VALID;
      default: state_d = ST_EMPTY;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q <= ST_EMPTY;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign load = (state_q == ST_EMPTY) || cfg_update;
  assign image_valid = (state_q == ST_VALID);

  // ----------------------------------------------------------------
  // field encoding
  // ----------------------------------------------------------------
  // a cable with no separable media reports no reach at all
  assign mm_ok = is_aoc ? 4'h0 : mm_supported;

  // reserved scale code would mislead the host, so report not supported
  assign smf_byte = (smf_supported && !is_aoc && singlemode_reach_scale != SCALE_RSVD)
                  ? {singlemode_reach_scale, singlemode_reach_base_km}
                  : 8'h00;

  // programmable single-wavelength lasers always show live values; fixed ones may tighten
  always_comb
  begin
    lambda_val = 16'h0000;
    tol_val = 16'h0000;
    if (single_lambda && (lambda_programmable || use_actual_lambda))
    begin
      lambda_val = act_nominal_tx_lambda;
      tol_val = act_tx_lambda_tolerance;
    end
    else if (single_lambda)
    begin
      lambda_val = std_nominal_tx_lambda;
      tol_val = std_tx_lambda_tolerance;
    end
    else if (multi_lambda_report)
    begin
      lambda_val = act_nominal_tx_lambda;
      tol_val = act_tx_lambda_tolerance;
    end
  end

  // reserved bank code falls back to the single bank the host always knows
  always_comb
  begin
    pages_byte = 8'h00;
    pages_byte[PG_NETPATH_BIT] = netpath_pages_present;
    pages_byte[PG_VENDOR_DIAG_BIT] = vendor_diag_pages_present;
    pages_byte[PG_DIAG_BIT] = diag_pages_present;
    pages_byte[PG_RESERVED_BIT] = 1'b0;
    pages_byte[PG_FORMFACTOR_BIT] = formfactor_page_present;
    pages_byte[PG_USER_BIT] = user_page_present;
    pages_byte[1:0] = (lane_bank_count_code == BANKS_RSVD)
                    ? BANKS_8_LANES : lane_bank_count_code;
  end

  // ----------------------------------------------------------------
  // advertising image
  // ----------------------------------------------------------------
  // byte 0 sits at the lowest address; writes never reach this path
  always_comb
  begin
    img_d = img_q;
    if (load)
    begin
      img_d = {pages_byte,
               tol_val[7:0], tol_val[15:8],
               lambda_val[7:0], lambda_val[15:8],
               RESERVED_VALUE,
               mm_ok[MM_LEGACY] ? legacy_mm_reach_1m : 8'h00,
               mm_ok[MM_EXT_BW] ? ext_bw_mm_reach_2m : 8'h00,
               mm_ok[MM_HIGH_BW] ? high_bw_mm_reach_2m : 8'h00,
               mm_ok[MM_WIDEBAND] ? wideband_mm_reach_2m : 8'h00,
               smf_byte};
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      img_q <= {ADV_BYTES{BYTE_RESET}};
    end
    else
    begin
      img_q <= img_d;
    end
  end

  // ----------------------------------------------------------------
  // management read port
  // ----------------------------------------------------------------
  // one-cycle read latency; writes are accepted silently and dropped
  always_comb
  begin
    rd_valid_d = mem_rd;
    rd_hit_d = mem_rd && in_block(mem_addr);
    rd_data_d = mem_rd ? byte_at(mem_addr, img_q) : 8'h00;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rd_valid_q <= 1'b0;
      rd_hit_q <= 1'b0;
      rd_data_q <= 8'h00;
    end
    else
    begin
      rd_valid_q <= rd_valid_d;
      rd_hit_q <= rd_hit_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ----------------------------------------------------------------
  // checksum share
  // ----------------------------------------------------------------
  // the page checksum owner adds this to the other bytes it covers
  mrwpa_byte_sum #(
    .NBYTES(ADV_BYTES)
  ) u_sum (
    .clock(clock),
    .sys_rst(sys_rst),
    .bytes_in(img_q),
    .sum_q(csum_part_q)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [7:0] img_sum;
  always_comb
  begin
    img_sum = 8'h00;
    for (int i = 0; i < ADV_BYTES; i++)
    begin
      img_sum = img_sum + img_q[i*8 +: 8];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // reach bytes: byte 0 is single-mode, bytes 1 to 4 the multimode classes
  aoc_reach_zero_a: assert property (load && is_aoc |=> img_q[39:0] == 40'h0)
    else $error("cable reports nonzero reach");
  unsup_mm_zero_a: assert property (
      load && !mm_supported[MM_LEGACY] |=> img_q[39:32] == 8'h00)
    else $error("unsupported fiber reach not zero");
  wide_reach_a: assert property (
      load && !is_aoc && mm_supported[MM_WIDEBAND]
      |=> img_q[15:8] == $past(wideband_mm_reach_2m))
    else $error("wideband reach not passed through");
  smf_field_a: assert property (
      load && smf_supported && !is_aoc && singlemode_reach_scale == SCALE_TEN
      |=> img_q[7:0] == {SCALE_TEN, $past(singlemode_reach_base_km)})
    else $error("single-mode byte mispacked");
  // reserved codes never reach the host, whatever the configuration asks for
  rsvd_fields_a: assert property (img_q[47:40] == 8'h00 && img_q[84] == 1'b0
      && img_q[81:80] != BANKS_RSVD && img_q[7:6] != SCALE_RSVD)
    else $error("reserved field nonzero");
  bank_code_a: assert property (
      load && lane_bank_count_code != BANKS_RSVD
      |=> img_q[81:80] == $past(lane_bank_count_code))
    else $error("lane bank code not passed through");
  // wavelength pairs sit high byte first
  prog_lambda_a: assert property (load && single_lambda && lambda_programmable
      |=> {img_q[55:48], img_q[63:56]} == $past(act_nominal_tx_lambda))
    else $error("programmable wavelength not actual");
  fixed_tol_a: assert property (
      load && single_lambda && !lambda_programmable && !use_actual_lambda
      |=> {img_q[71:64], img_q[79:72]} == $past(std_tx_lambda_tolerance))
    else $error("fixed tolerance not standard");
  // static image, read port and checksum share
  static_image_a: assert property (!load |=> $stable(img_q))
    else $error("image changed without reconfiguration");
  read_data_a: assert property (
      mem_rd && mem_addr == OFF_OPTIONAL_PAGE_SUPPORT && !load
      |=> rd_valid_q && rd_hit_q && rd_data_q == img_q[87:80])
    else $error("page byte read wrong");
  read_miss_a: assert property (
      mem_rd && !in_block(mem_addr) |=> rd_valid_q && !rd_hit_q && rd_data_q == 8'h00)
    else $error("read outside the block not refused");
  csum_share_a: assert property (!load [*2] |-> csum_part_q == img_sum)
    else $error("checksum share mismatch");

  read_rsvd_c: cover property (mem_rd && mem_addr == OFF_REACH_RESERVED ##1 rd_valid_q);
  write_drop_c: cover property (mem_wr && in_block(mem_addr) && mem_wdata != 8'h00);
  retune_c: cover property (image_valid && cfg_update && lambda_programmable);
  aoc_c: cover property (load && is_aoc && |mm_supported);

endmodule

/* File: tb/mrwpa_host_model.sv */
// host controller model that reads and writes bytes of the module page
`timescale 1ns/100ps
module mrwpa_host_model (
  input wire logic clock,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] rd_data_q,
  input wire logic rd_valid_q,
  input wire logic rd_hit_q
);
  // idle bus at time zero
  initial
  begin
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    mem_addr = 8'h00;
    mem_wdata = 8'h00;
  end

  // one read strobe; the byte is taken in the cycle after the strobe edge
  // the host uses the bytes as given, wavelength bytes of a multi-wavelength part included
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v,
                           output logic h);
    @(posedge clock);
    #1;
    mem_rd = 1'b1;
    mem_addr = a;
    @(posedge clock);
    #1;
    mem_rd = 1'b0;
    mem_addr = ~a; // released address never shows the stale value
    d = rd_data_q;
    v = rd_valid_q;
    h = rd_hit_q;
  endtask

  // one write strobe; the bank must ignore it
  task automatic write_byte(input logic [7:0] a, input logic [7:0] w);
    @(posedge clock);
    #1;
    mem_wr = 1'b1;
    mem_addr = a;
    mem_wdata = w;
    @(posedge clock);
    #1;
    mem_wr = 1'b0;
    mem_addr = ~a;
    mem_wdata = ~w;
  endtask
endmodule

/* File: tb/tb_mrwpa_adv_bank.sv */
// self-checking bench for the reach, wavelength and page advertising bank
`timescale 1ns/100ps
module tb_mrwpa_adv_bank;
  import mrwpa_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_update = 1'b0;
  logic is_aoc = 1'b0;
  logic smf_supported = 1'b1;
  logic [3:0] mm_supported = 4'hf;
  logic [1:0] singlemode_reach_scale = 2'h2;
  logic [5:0] singlemode_reach_base_km = 6'h3f;
  logic [7:0] wideband_mm_reach_2m = 8'hff;
  logic [7:0] high_bw_mm_reach_2m = 8'h96;
  logic [7:0] ext_bw_mm_reach_2m = 8'h46;
  logic [7:0] legacy_mm_reach_1m = 8'h01;
  logic single_lambda = 1'b1;
  logic lambda_programmable = 1'b0;
  logic use_actual_lambda = 1'b0;
  logic multi_lambda_report = 1'b0;
  logic [15:0] std_nominal_tx_lambda = 16'h77dd;
  logic [15:0] std_tx_lambda_tolerance = 16'h002f;
  logic [15:0] act_nominal_tx_lambda = 16'h65bf;
  logic [15:0] act_tx_lambda_tolerance = 16'h061e;
  logic netpath_pages_present = 1'b1;
  logic vendor_diag_pages_present = 1'b0;
  logic diag_pages_present = 1'b1;
  logic formfactor_page_present = 1'b0;
  logic user_page_present = 1'b1;
  logic [1:0] lane_bank_count_code = 2'h2;
  logic mem_rd, mem_wr, rd_valid_q, rd_hit_q, image_valid;
  logic [7:0] mem_addr, mem_wdata, rd_data_q, csum_part_q;
  logic [7:0] exp_img [0:10];
  int n_mismatch = 0;
  int n_tests = 0;

  always #25 clock = ~clock;

  mrwpa_adv_bank u_mrwpa_adv_bank (.clock(clock), .sys_rst(sys_rst), .cfg_update(cfg_update),
    .is_aoc(is_aoc), .smf_supported(smf_supported), .mm_supported(mm_supported),
    .singlemode_reach_scale(singlemode_reach_scale),
    .singlemode_reach_base_km(singlemode_reach_base_km),
    .wideband_mm_reach_2m(wideband_mm_reach_2m), .high_bw_mm_reach_2m(high_bw_mm_reach_2m),
    .ext_bw_mm_reach_2m(ext_bw_mm_reach_2m), .legacy_mm_reach_1m(legacy_mm_reach_1m),
    .single_lambda(single_lambda), .lambda_programmable(lambda_programmable),
    .use_actual_lambda(use_actual_lambda), .multi_lambda_report(multi_lambda_report),
    .std_nominal_tx_lambda(std_nominal_tx_lambda),
    .std_tx_lambda_tolerance(std_tx_lambda_tolerance),
    .act_nominal_tx_lambda(act_nominal_tx_lambda),
    .act_tx_lambda_tolerance(act_tx_lambda_tolerance),
    .netpath_pages_present(netpath_pages_present),
    .vendor_diag_pages_present(vendor_diag_pages_present),
    .diag_pages_present(diag_pages_present), .formfactor_page_present(formfactor_page_present),
    .user_page_present(user_page_present), .lane_bank_count_code(lane_bank_count_code),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .rd_hit_q(rd_hit_q),
    .image_valid(image_valid), .csum_part_q(csum_part_q));

  mrwpa_host_model u_mrwpa_host_model (.clock(clock), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .rd_hit_q(rd_hit_q));

  // expected page byte worked out from the current configuration
  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    logic act;
    logic [15:0] nom;
    logic [15:0] tol;
    act = single_lambda ? (lambda_programmable | use_actual_lambda) : multi_lambda_report;
    nom = act ? act_nominal_tx_lambda : (single_lambda ? std_nominal_tx_lambda : 16'h0000);
    tol = act ? act_tx_lambda_tolerance : (single_lambda ? std_tx_lambda_tolerance : 16'h0000);
    case (a)
      8'h84: exp_byte = (smf_supported && !is_aoc && singlemode_reach_scale != 2'h3) ?
        {singlemode_reach_scale, singlemode_reach_base_km} : 8'h00;
      8'h85: exp_byte = (mm_supported[0] && !is_aoc) ? wideband_mm_reach_2m : 8'h00;
      8'h86: exp_byte = (mm_supported[1] && !is_aoc) ? high_bw_mm_reach_2m : 8'h00;
      8'h87: exp_byte = (mm_supported[2] && !is_aoc) ? ext_bw_mm_reach_2m : 8'h00;
      8'h88: exp_byte = (mm_supported[3] && !is_aoc) ? legacy_mm_reach_1m : 8'h00;
      8'h8a: exp_byte = nom[15:8];
      8'h8b: exp_byte = nom[7:0];
      8'h8c: exp_byte = tol[15:8];
      8'h8d: exp_byte = tol[7:0];
      8'h8e:
        exp_byte = {netpath_pages_present, vendor_diag_pages_present, diag_pages_present,
          1'b0, formfactor_page_present, user_page_present,
          (lane_bank_count_code == 2'h3) ? 2'h0 : lane_bank_count_code};
      default: exp_byte = 8'h00; // reserved byte and unmapped places
    endcase
  endfunction

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  // snapshot of the image the bank should hold from now on
  task automatic snap();
    for (int i = 0; i < ADV_BYTES; i++)
      exp_img[i] = exp_byte(ADV_BASE + 8'(i));
  endtask

  // take a new configuration with a one-cycle update pulse
  task automatic load();
    snap();
    @(posedge clock);
    #1;
    cfg_update = 1'b1;
    @(posedge clock);
    #1;
    cfg_update = 1'b0;
  endtask

  // read every byte of the block, then the checksum share
  task automatic check_all();
    logic [7:0] d;
    logic v;
    logic h;
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < ADV_BYTES; i++)
    begin
      u_mrwpa_host_model.read_byte(ADV_BASE + 8'(i), d, v, h);
      cmp8("page byte", exp_img[i], d);
      cmp1("read valid", 1'b1, v);
      cmp1("read hit", 1'b1, h);
      sum = sum + exp_img[i];
    end
    cmp8("checksum share", sum, csum_part_q);
  endtask

  // outputs quiet in reset, image loaded from the inputs after release
  task automatic t_reset();
    repeat (20) @(posedge clock);
    #1;
    cmp1("image valid in reset", 1'b0, image_valid);
    cmp8("read data in reset", 8'h00, rd_data_q);
    sys_rst = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    cmp1("image valid", 1'b1, image_valid);
    snap();
    check_all();
  endtask

  // every scale and bank code, each fiber class alone, page flags shifted right
  task automatic t_codes();
    for (int i = 0; i < 4; i++)
    begin
      singlemode_reach_scale = 2'(i);
      lane_bank_count_code = 2'(i);
      mm_supported = 4'h1 << i;
      smf_supported = (i != 1);
      {netpath_pages_present, vendor_diag_pages_present, diag_pages_present,
        formfactor_page_present, user_page_present} = 5'h15 >> i;
      load();
      check_all();
    end
  endtask

  // an active optical cable reports no reach at all
  task automatic t_aoc();
    is_aoc = 1'b1;
    smf_supported = 1'b1;
    singlemode_reach_scale = 2'h1;
    mm_supported = 4'hf;
    load();
    check_all();
    is_aoc = 1'b0;
  endtask

  // all combinations of the wavelength mode selects
  task automatic t_lambda();
    for (int m = 0; m < 16; m++)
    begin
      {single_lambda, lambda_programmable, use_actual_lambda, multi_lambda_report} = 4'(m);
      load();
      check_all();
    end
  endtask

  // inputs move and the host writes, but the image stays; unmapped reads miss
  task automatic t_static();
    logic [7:0] d;
    logic v;
    logic h;
    logic [7:0] miss [0:2];
    miss = '{8'h83, 8'h8f, 8'h00};
    smf_supported = ~smf_supported;
    mm_supported = ~mm_supported;
    act_nominal_tx_lambda = ~act_nominal_tx_lambda;
    netpath_pages_present = ~netpath_pages_present;
    for (int i = 0; i < ADV_BYTES; i++)
      u_mrwpa_host_model.write_byte(ADV_BASE + 8'(i), 8'hff);
    check_all();
    foreach (miss[k])
    begin
      u_mrwpa_host_model.read_byte(miss[k], d, v, h);
      cmp8("unmapped data", 8'h00, d);
      cmp1("unmapped hit", 1'b0, h);
      cmp1("unmapped valid", 1'b1, v);
    end
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    t_reset();
    t_codes();
    t_aoc();
    t_lambda();
    t_static();
    give_verdict();
  end

  // the tests need under 2000 cycles; a hang is cut short well after that
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    give_verdict();
  end
endmodule
